// [include/panel_if.sv]
// Connection between the control module end and the display board end.
`timescale 1ns/1ps
interface panel_if;
   import panel_pkg::*;
   logic      earlyTimingPulse;
   logic      lateTimingPulse;
   byte_t     addrLines;
   byte_t     systemDataLines;
   logic      dataLatchPulse;
   lamps_t    lampLines;
   switches_t switchContacts;
   modport control
   (
      output earlyTimingPulse,
      output lateTimingPulse,
      output addrLines,
      output systemDataLines,
      output dataLatchPulse,
      output lampLines,
      input  switchContacts
   );
   modport display
   (
      input  earlyTimingPulse,
      input  lateTimingPulse,
      input  addrLines,
      input  systemDataLines,
      input  dataLatchPulse,
      input  lampLines,
      output switchContacts
   );
endinterface

// [include/panel_map.svh]
// Constants for the front-panel bus display: field positions and widths.
`ifndef PANEL_MAP_SVH
`define PANEL_MAP_SVH
`define NIBBLE_W      4
`define BYTE_W        8
`define SEG_W         7
`define DIGIT_COUNT   6
`define LAMP_COUNT    6
`define SWITCH_COUNT  6
`define NIB_LO_MSB    3
`define NIB_HI_LSB    4
`define NIB_HI_MSB    7
`define LAMP_WAIT     0
`define LAMP_CLEAR    1
`define LAMP_SC_LOW   2
`define LAMP_SC_HIGH  3
`define LAMP_FLAG     4
`define LAMP_RUN      5
`define SW_RESET      0
`define SW_RUN_UTIL   1
`define SW_RUN_PROG   2
`define SW_LOAD       3
`define SW_STEP_MODE  4
`define SW_DISP_SRC   5
`endif

// [include/panel_pkg.sv]
// Types shared by the processor-side end and the display end.
package panel_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] nibble_t;
   typedef logic [6:0] seg_t;
   typedef logic [5:0] lamps_t;
   typedef logic [5:0] switches_t;
   // Display source toggle: live bus or last I/O byte.
   typedef enum logic [1:0]
   {
      SRC_BUS     = 2'b01,
      SRC_LAST_IO = 2'b10
   } source_t;
endpackage

// [logic/panel_control.sv]
// Control module end: drives bus view, lamps and the last-I/O latch pulse.
`timescale 1ns/1ps
`include "panel_map.svh"
module panel_control
(
   panel_if.control                 link,
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                cpuEarlyPulse,
   input  wire logic                cpuLatePulse,
   input  wire panel_pkg::byte_t    cpuAddr,
   input  wire panel_pkg::byte_t    cpuData,
   input  wire logic [2:0]          ioCodeLines,
   input  wire logic                waitLine,
   input  wire logic                clearLine,
   input  wire logic                stateCodeBitLow,
   input  wire logic                stateCodeBitHigh,
   input  wire logic                flagOut,
   input  wire logic                runState,
   input  wire panel_pkg::source_t  dataSource,
   output panel_pkg::switches_t     switchesSeen
);
   import panel_pkg::*;

   logic    latch_q;
   logic    latch_d;
   lamps_t  lamps_d;

   // Latch pulse at the late pulse of any I/O cycle when showing last I/O.
   always_comb
   begin
      latch_d = (dataSource == SRC_LAST_IO) && cpuLatePulse && (|ioCodeLines);
      lamps_d = 6'h00;
      lamps_d[`LAMP_WAIT]    = waitLine;
      lamps_d[`LAMP_CLEAR]   = clearLine;
      lamps_d[`LAMP_SC_LOW]  = stateCodeBitLow;
      lamps_d[`LAMP_SC_HIGH] = stateCodeBitHigh;
      lamps_d[`LAMP_FLAG]    = flagOut;
      lamps_d[`LAMP_RUN]     = runState;
   end

   // Registers the strobe.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         latch_q <= 1'b0;
      end
      else
      begin
         latch_q <= latch_d;
      end
   end

   // Processor lines pass to the display; data latch sampled with registered strobe.
   assign link.earlyTimingPulse = cpuEarlyPulse;
   assign link.lateTimingPulse  = cpuLatePulse;
   assign link.addrLines        = cpuAddr;
   assign link.systemDataLines  = cpuData;
   assign link.dataLatchPulse   = latch_q;
   assign link.lampLines        = lamps_d;
   assign switchesSeen          = link.switchContacts;
endmodule // panel_control

// [logic/panel_display.sv]
// Display board end: six hex digits, six lamps and six switch contacts.
`timescale 1ns/1ps
`include "panel_map.svh"

// How it works
// - High address byte captured at early pulse
// - Middle digits follow live address lines
// - Each digit decodes a nibble to hex
// - Address shown every cycle, no qualification
// - Fetch and execute addresses both displayed
// - Bus position: data digits follow bus
// - Last-I/O position: control pulses latch at late I/O pulse
// - Six lamps lit while condition true
// - Six switch contacts pass a two-stage synchroniser
// - Control supplies the run indicator
// - I/O cycle is OR of code lines
// - Processor supplies early and late pulses
module panel_display
(
   panel_if.display                 link,
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire panel_pkg::switches_t switchesRaw,
   input  wire panel_pkg::source_t  dataSource,
   output logic [`SEG_W-1:0]        digitSegs [`DIGIT_COUNT],
   output panel_pkg::lamps_t        lampLeds
);
   import panel_pkg::*;

   // The display end only watches: it never drives the bus that it shows. Every output
   // is a register on clk, and all timing comes from the pulses that the control end
   // passes on, so one clock is enough for the whole board.

   // Latched bytes and their next values.
   byte_t   highAddr_q;
   byte_t   highAddr_d;
   byte_t   dataHeld_q;
   byte_t   dataHeld_d;
   // Digit sources and patterns.
   byte_t   shown [`DIGIT_COUNT/2];
   seg_t    segs_q [`DIGIT_COUNT];
   seg_t    segs_d [`DIGIT_COUNT];
   // Lamp register and its next value.
   lamps_t  lamps_q;
   lamps_t  lamps_d;
   // Switch synchroniser stages and their next values.
   switches_t swMeta_q;
   switches_t swMeta_d;
   switches_t swOut_q;
   switches_t swOut_d;

   // Converts one nibble to an active-high seven-segment pattern, gfedcba.
   // The letters b and d use lower-case shapes so that they are not read as 8 and 0.
   // An unknown nibble blanks the digit rather than showing a wrong symbol.
   function automatic seg_t hexSegs(input nibble_t n);
      case (n)
         4'h0: hexSegs = 7'h3F;
         4'h1: hexSegs = 7'h06;
         4'h2: hexSegs = 7'h5B;
         4'h3: hexSegs = 7'h4F;
         4'h4: hexSegs = 7'h66;
         4'h5: hexSegs = 7'h6D;
         4'h6: hexSegs = 7'h7D;
         4'h7: hexSegs = 7'h07;
         4'h8: hexSegs = 7'h7F;
         4'h9: hexSegs = 7'h6F;
         4'hA: hexSegs = 7'h77;
         4'hB: hexSegs = 7'h7C;
         4'hC: hexSegs = 7'h39;
         4'hD: hexSegs = 7'h5E;
         4'hE: hexSegs = 7'h79;
         4'hF: hexSegs = 7'h71;
         default: hexSegs = 7'h00;
      endcase
   endfunction

   // Next value of the high address latch. It loads on every early pulse, whatever the
   // cycle does with memory, so the leftmost digits always show the page of the cycle.
   always_comb
   begin
      highAddr_d = highAddr_q;
      if (link.earlyTimingPulse)
      begin
         highAddr_d = link.addrLines;
      end
   end

   // High address latch register. It has no reset on purpose: a reset must not wipe the
   // page on show, and until the first early pulse it holds no defined value.
   always_ff @(posedge clk)
   begin
      highAddr_q <= highAddr_d;
   end

   // Next value of the held data byte. Only the control end decides when it loads, so a
   // late pulse by itself never disturbs what the rightmost digits hold.
   always_comb
   begin
      dataHeld_d = dataHeld_q;
      if (link.dataLatchPulse)
      begin
         dataHeld_d = link.systemDataLines;
      end
   end

   // Held data register, also without reset, so the last I/O byte survives a reset.
   always_ff @(posedge clk)
   begin
      dataHeld_q <= dataHeld_d;
   end

   // Source bytes for the three digit pairs: pair 0 is the held high address, pair 1 the
   // live low address, and pair 2 either the live data lines or the held I/O byte.
   // A selector code other than the last-I/O one falls back to the live data lines, so a
   // toggle caught between its two contacts never freezes the data digits.
   always_comb
   begin
      shown[0] = highAddr_q;
      shown[1] = link.addrLines;
      case (dataSource)
         SRC_LAST_IO: shown[2] = dataHeld_q;
         SRC_BUS:     shown[2] = link.systemDataLines;
         default:     shown[2] = link.systemDataLines;
      endcase
   end

   // Decodes each nibble of each byte into a digit pattern. The even digit of a pair
   // carries the high nibble and the odd digit the low nibble, so digit 0 is the leftmost
   // and each byte reads left to right.
   genvar g;
   generate
      for (g = 0; g < `DIGIT_COUNT/2; g++)
      begin : g_pair
         always_comb
         begin
            segs_d[2*g]   = hexSegs(shown[g][`NIB_HI_MSB:`NIB_HI_LSB]);
            segs_d[2*g+1] = hexSegs(shown[g][`NIB_LO_MSB:0]);
         end
      end
   endgenerate

   // Next values of the lamp and switch registers.
   // The lamp levels come from logic on this clock, so one register is enough for them.
   // The switch contacts come straight from panel pins and may move at any time, so they
   // pass a first stage that nothing but the second stage reads.
   always_comb
   begin
      lamps_d  = link.lampLines;
      swMeta_d = switchesRaw;
      swOut_d  = swMeta_q;
   end

   // Digit pattern registers; every digit is blank while reset is held.
   // The held bytes behind them are untouched, so the digits come back after reset.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < `DIGIT_COUNT; i++)
         begin
            segs_q[i] <= 7'h00;
         end
      end
      else
      begin
         for (int i = 0; i < `DIGIT_COUNT; i++)
         begin
            segs_q[i] <= segs_d[i];
         end
      end
   end

   // Lamp register; every lamp is dark while reset is held.
   // The lamps show levels, not pulses, so one cycle of lag is never seen.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lamps_q <= 6'h00;
      end
      else
      begin
         lamps_q <= lamps_d;
      end
   end

   // Two-stage switch synchroniser; the contacts read as open while reset is held.
   // Contact bounce is left to the control module, which sees the synchronised closures.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         swMeta_q <= 6'h00;
         swOut_q  <= 6'h00;
      end
      else
      begin
         swMeta_q <= swMeta_d;
         swOut_q  <= swOut_d;
      end
   end

   // Outputs come straight from their registers, so the panel never shows a glitch.
   assign digitSegs           = segs_q;
   assign lampLeds            = lamps_q;
   assign link.switchContacts = swOut_q;
endmodule // panel_display

// [tb/panel_monitor.sv]
// Checker on the signals between the control end and the display end.
`timescale 1ns/1ps
module panel_monitor
(
   input wire logic                 clk,
   input wire logic                 rstn,
   input wire logic                 earlyTimingPulse,
   input wire logic                 lateTimingPulse,
   input wire panel_pkg::byte_t     addrLines,
   input wire panel_pkg::byte_t     systemDataLines,
   input wire logic                 dataLatchPulse,
   input wire panel_pkg::lamps_t    lampLines,
   input wire panel_pkg::switches_t switchContacts
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // A latch pulse or a late pulse lasts one clock.
   sequence latchBlip; dataLatchPulse ##1 !dataLatchPulse; endsequence
   sequence lateBlip; lateTimingPulse ##1 !lateTimingPulse; endsequence
   a_latch_cause: assert property (dataLatchPulse |-> lateTimingPulse || $past(lateTimingPulse))
      else $error("latch pulse without late pulse");
   a_latch_width: assert property (dataLatchPulse |-> latchBlip)
      else $error("latch pulse too long");
   a_late_width: assert property (lateTimingPulse |-> lateBlip)
      else $error("late pulse too long");
   a_late_gap: assert property (lateTimingPulse |=> !lateTimingPulse [*2])
      else $error("late pulses too close");
   a_early_width: assert property (earlyTimingPulse |=> !earlyTimingPulse)
      else $error("early pulse too long");
   a_pulses_apart: assert property (!(earlyTimingPulse && lateTimingPulse))
      else $error("early and late pulses overlap");
   a_latch_off_early: assert property (dataLatchPulse |-> !earlyTimingPulse)
      else $error("latch pulse during early pulse");
   a_latch_after_reset: assert property ($rose(rstn) |-> !dataLatchPulse)
      else $error("latch pulse at reset release");
endmodule // panel_monitor

// [tb/testbench.sv]
// Self-checking bench for both panel ends joined by their interface.
`timescale 1ns/1ps
module testbench;
   import panel_pkg::*;
   typedef struct packed {byte_t a; byte_t d; lamps_t l; switches_t s;} row_t;
   logic       clk, rstn, cpuEarlyPulse, cpuLatePulse;
   byte_t      cpuAddr, cpuData;
   logic [2:0] ioCodeLines;
   lamps_t     lampIn, lampLeds;
   switches_t  switchesRaw, switchesSeen;
   source_t    dataSource;
   logic [6:0] digitSegs [6];
   int         num_errors, comparisons;
   logic [6:0] segTab [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                               7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
   row_t       rows [4] = '{'{8'h01, 8'h23, 6'h15, 6'h2A}, '{8'h45, 8'h67, 6'h2A, 6'h15},
                            '{8'h89, 8'hAB, 6'h3F, 6'h00}, '{8'hCD, 8'hEF, 6'h00, 6'h3F}};
   panel_if link ();
   panel_control i_panel_control (.link(link), .clk(clk), .rstn(rstn), .cpuEarlyPulse(cpuEarlyPulse),
      .cpuLatePulse(cpuLatePulse), .cpuAddr(cpuAddr), .cpuData(cpuData), .ioCodeLines(ioCodeLines),
      .waitLine(lampIn[0]), .clearLine(lampIn[1]), .stateCodeBitLow(lampIn[2]), .stateCodeBitHigh(lampIn[3]),
      .flagOut(lampIn[4]), .runState(lampIn[5]), .dataSource(dataSource), .switchesSeen(switchesSeen));
   panel_display i_panel_display (.link(link), .clk(clk), .rstn(rstn), .switchesRaw(switchesRaw),
      .dataSource(dataSource), .digitSegs(digitSegs), .lampLeds(lampLeds));
   panel_monitor i_panel_monitor (.clk(clk), .rstn(rstn), .earlyTimingPulse(link.earlyTimingPulse),
      .lateTimingPulse(link.lateTimingPulse), .addrLines(link.addrLines), .systemDataLines(link.systemDataLines),
      .dataLatchPulse(link.dataLatchPulse), .lampLines(link.lampLines), .switchContacts(link.switchContacts));
   // Free-running clock at 200 MHz.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Compares two adjacent digits with the segment patterns of one byte.
   task show(input int idx, input byte_t b);
      check($sformatf("digit %0d", idx), {1'b0, digitSegs[idx]}, {1'b0, segTab[b[7:4]]});
      check($sformatf("digit %0d", idx + 1), {1'b0, digitSegs[idx + 1]}, {1'b0, segTab[b[3:0]]});
   endtask
   // Gives one early or late pulse, then leaves the bus quiet for four clocks.
   task strobe(input bit late);
      if (late) cpuLatePulse <= 1'b1;
      else cpuEarlyPulse <= 1'b1;
      @(posedge clk);
      cpuLatePulse <= 1'b0;
      cpuEarlyPulse <= 1'b0;
      wait_clk(4);
   endtask
   task final_report;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Cuts a hung run short.
   initial
   begin
      repeat (5000) @(posedge clk);
      num_errors++;
      final_report();
   end
   // Table rows first, then latch, last-I/O and reset cases.
   initial
   begin
      {rstn, cpuEarlyPulse, cpuLatePulse, cpuAddr, cpuData, ioCodeLines, lampIn, switchesRaw} <= '0;
      dataSource <= SRC_BUS;
      wait_clk(6);
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         {cpuAddr, cpuData, lampIn, switchesRaw} <= rows[i];
         wait_clk(4);
         show(2, rows[i].a);
         show(4, rows[i].d);
         check("lamps", {2'b00, lampLeds}, {2'b00, rows[i].l});
         check("switches", {2'b00, switchesSeen}, {2'b00, rows[i].s});
         $display("row %0d done", i);
      end
      cpuAddr <= 8'h5A;
      strobe(0);
      cpuAddr <= 8'hC3;
      wait_clk(4);
      show(0, 8'h5A);
      show(2, 8'hC3);
      $display("address latch test done");
      dataSource <= SRC_LAST_IO;
      for (int k = 0; k < 3; k++)
      begin
         ioCodeLines <= 3'(1 << k);
         cpuData <= 8'hA0 + 8'(k);
         strobe(1);
         cpuData <= 8'h47;
         wait_clk(4);
         show(4, 8'hA0 + 8'(k));
      end
      ioCodeLines <= 3'b000;
      strobe(1);
      show(4, 8'hA2);
      dataSource <= SRC_BUS;
      wait_clk(4);
      show(4, 8'h47);
      // A late pulse of an I/O cycle in the bus position must not load the held byte.
      ioCodeLines <= 3'b111;
      cpuData <= 8'h99;
      strobe(1);
      dataSource <= SRC_LAST_IO;
      wait_clk(4);
      show(4, 8'hA2);
      $display("last io test done");
      rstn <= 1'b0;
      lampIn <= 6'h3F;
      wait_clk(2);
      check("lamps in reset", {2'b00, lampLeds}, 8'h00);
      check("segments in reset", {1'b0, digitSegs[2]}, 8'h00);
      rstn <= 1'b1;
      wait_clk(2);
      check("lamps after reset", {2'b00, lampLeds}, 8'h3F);
      show(0, 8'h5A);
      $display("reset test done");
      final_report();
   end
endmodule // testbench
